// ### logic/swwd_pkg.sv
// Shared constants and types for the supervisor with window watchdog.
// Assumes a 10 MHz core clock; all intervals are counted in its cycles.
package swwd_pkg;

  // ------------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1_000;
  localparam int unsigned CNT_W       = 24;

  // ------------------------------------------------------------------
  // Intervals in their own units, then in cycles
  // ------------------------------------------------------------------
  localparam int unsigned RST_HOLD_MS   = 200;
  localparam int unsigned WDL_FLOAT_MS  = 800;
  localparam int unsigned WDU_FLOAT_MS  = 1600;
  localparam int unsigned WDL_PULLUP_US = 1850;   // 1.85 ms
  localparam int unsigned WDU_PULLUP_US = 11000;  // 11.0 ms
  localparam int unsigned PROBE_US      = 381;
  localparam int unsigned SETTLE_US     = 150;
  localparam int unsigned RST_HOLD_CYC   = RST_HOLD_MS * CYC_PER_MS;
  localparam int unsigned WDL_FLOAT_CYC  = WDL_FLOAT_MS * CYC_PER_MS;
  localparam int unsigned WDU_FLOAT_CYC  = WDU_FLOAT_MS * CYC_PER_MS;
  localparam int unsigned WDL_PULLUP_CYC = WDL_PULLUP_US * CYC_PER_US;
  localparam int unsigned WDU_PULLUP_CYC = WDU_PULLUP_US * CYC_PER_US;
  localparam logic [CNT_W-1:0] PROBE_CYC  = CNT_W'(PROBE_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(SETTLE_US * CYC_PER_US);
  // Timing-select probe: quiet sense, then charge-time thresholds
  localparam logic [CNT_W-1:0] SENSE_CYC  = 24'h000008;
  localparam logic [CNT_W-1:0] FLOAT_MAX  = 24'h000010;
  localparam logic [11:0]      CAP_LO_MUL = 12'h020;
  localparam logic [11:0]      CAP_UP_MUL = 12'h040;

  // ------------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_IRQ_EN  = 8'h04;
  localparam logic [7:0] REG_IRQ_CLR = 8'h08;
  localparam logic [7:0] REG_STATE   = 8'h0C;
  localparam logic [7:0] REG_CAPCNT  = 8'h10;
  localparam logic [2:0] IRQ_EN_RST  = 3'h0;
  localparam int unsigned EV_RESET = 0;  // reset output asserted
  localparam int unsigned EV_FAULT = 1;  // window violation
  localparam int unsigned EV_PROBE = 2;  // timing-select probe done

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {MODE_FLOAT, MODE_PULLUP, MODE_CAP} swwd_mode_t;
  typedef enum logic [1:0] {PR_IDLE, PR_SENSE, PR_RUN, PR_DONE} swwd_probe_t;
  typedef enum logic [1:0] {WD_OFF, WD_SETTLE, WD_FIRST, WD_WINDOW} swwd_wd_t;

  typedef struct packed {
    logic uv_low;     // comparator: supply below threshold
    logic mr_n;       // manual reset pin level
    logic mr_drv;     // manual reset pin actively driven
    logic kick;       // watchdog kick pin level
    logic wd_en;      // watchdog enable pin level
    logic cwd_high;   // timing-select pin above its threshold
  } swwd_pins_t;

endpackage : swwd_pkg

// ### logic/swwd_core.sv
// Digital core of a supply supervisor with a window watchdog.
// Assumes pins arrive asynchronously and open-drain pads resolve levels.
`timescale 1ns/1ps
module swwd_core
  import swwd_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = RST_HOLD_CYC,
  parameter int unsigned WDL_F_CYC = WDL_FLOAT_CYC,
  parameter int unsigned WDU_F_CYC = WDU_FLOAT_CYC,
  parameter int unsigned WDL_P_CYC = WDL_PULLUP_CYC,
  parameter int unsigned WDU_P_CYC = WDU_PULLUP_CYC
) (
  input  wire logic        clock,                   // 10 MHz core clock
  input  wire logic        resetn,                  // Sync power-on reset
  input  wire logic        undervoltage_low,        // Supply comparator
  input  wire logic        manual_reset_n,          // Manual reset pin
  input  wire logic        manual_reset_drv,        // Pin is driven
  input  wire logic        watchdog_kick_in,        // Kick pin
  input  wire logic        watchdog_enable_pin,     // Watchdog enable
  input  wire logic        window_timing_select_pin,// Pin above threshold
  output logic             timing_charge_en,        // Charge current on
  output logic             reset_out_n_o,           // Open-drain value
  output logic             reset_out_n_oe,          // Pulls reset low
  output logic             watchdog_fault_out_n_o,  // Open-drain value
  output logic             watchdog_fault_out_n_oe, // Pulls fault low
  output logic             irq,                     // Level interrupt
  input  wire logic [7:0]  reg_addr,                // Register address
  input  wire logic [31:0] reg_wdata,               // Write data
  input  wire logic        reg_wr,                  // Write strobe
  input  wire logic        reg_rd,                  // Read strobe
  output logic      [31:0] reg_rdata                // Data, cycle after
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  swwd_pins_t pins_raw;
  swwd_pins_t meta_r, sync_r, prev_r;
  swwd_pins_t meta_nxt, sync_nxt, prev_nxt;
  logic       mr_low, cause, kick_fall;

  assign pins_raw = '{uv_low:   undervoltage_low,
                      mr_n:     manual_reset_n,
                      mr_drv:   manual_reset_drv,
                      kick:     watchdog_kick_in,
                      wd_en:    watchdog_enable_pin,
                      cwd_high: window_timing_select_pin};

  // Two stages per pin, plus a delayed copy for the kick edge; the first stage feeds no logic
  always_comb begin
    meta_nxt = pins_raw;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      meta_r <= '{uv_low: 1'b1, mr_n: 1'b1, mr_drv: 1'b0, kick: 1'b1,
                  wd_en: 1'b0, cwd_high: 1'b0};
      sync_r <= '{uv_low: 1'b1, mr_n: 1'b1, mr_drv: 1'b0, kick: 1'b1,
                  wd_en: 1'b0, cwd_high: 1'b0};
      prev_r <= '{uv_low: 1'b1, mr_n: 1'b1, mr_drv: 1'b0, kick: 1'b1,
                  wd_en: 1'b0, cwd_high: 1'b0};
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Undriven manual reset pin counts as high (internal pull-up)
  assign mr_low    = sync_r.mr_drv & ~sync_r.mr_n;
  assign cause     = sync_r.uv_low | mr_low;
  // Edge seen on synced copies; pulses shorter than a cycle may be lost
  assign kick_fall = prev_r.kick & ~sync_r.kick;

  // ------------------------------------------------------------------
  // Timing-select probe
  // ------------------------------------------------------------------
  swwd_probe_t      pr_r, pr_nxt;
  logic [CNT_W-1:0] pr_cnt_r, pr_cnt_nxt;
  logic [CNT_W-1:0] cap_r, cap_nxt;
  logic             rose_r, rose_nxt;
  swwd_mode_t       mode_r, mode_nxt;
  logic             chg_r, chg_nxt;
  logic             rst_act_r;

  // Restarts whenever a reset cause is present, runs once it clears
  always_comb begin
    pr_nxt     = pr_r;
    pr_cnt_nxt = pr_cnt_r + 1'b1;
    cap_nxt    = cap_r;
    rose_nxt   = rose_r;
    mode_nxt   = mode_r;
    chg_nxt    = 1'b0;
    case (pr_r)
      PR_IDLE: begin
        pr_cnt_nxt = '0;
        if (!cause) begin
          pr_nxt = PR_SENSE;
        end
      end
      PR_SENSE: begin
        // Charge off: only a pull-up reads high here
        if (pr_cnt_r == SENSE_CYC) begin
          rose_nxt   = 1'b0;
          pr_cnt_nxt = '0;
          if (sync_r.cwd_high) begin
            mode_nxt = MODE_PULLUP;
            rose_nxt = 1'b1;
          end
          pr_nxt  = PR_RUN;
          chg_nxt = ~sync_r.cwd_high;
        end
      end
      PR_RUN: begin
        chg_nxt = ~rose_r;
        if (!rose_r && sync_r.cwd_high) begin
          rose_nxt = 1'b1;
          cap_nxt  = pr_cnt_r;
          mode_nxt = (pr_cnt_r < FLOAT_MAX) ? MODE_FLOAT
                                            : MODE_CAP;
        end
        if (pr_cnt_r + SENSE_CYC >= PROBE_CYC - 1'b1) begin
          pr_nxt = PR_DONE;
          if (!rose_r && !sync_r.cwd_high) begin
            mode_nxt = MODE_CAP;                          // Saturated
            cap_nxt  = pr_cnt_r;
          end
        end
      end
      PR_DONE: begin
        pr_cnt_nxt = pr_cnt_r;
      end
      default: pr_nxt = PR_IDLE;
    endcase
    if (cause) begin
      pr_nxt = PR_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pr_r     <= PR_IDLE;
      pr_cnt_r <= '0;
      cap_r    <= '0;
      rose_r   <= 1'b0;
      mode_r   <= MODE_FLOAT;
      chg_r    <= 1'b0;
    end else begin
      pr_r     <= pr_nxt;
      pr_cnt_r <= pr_cnt_nxt;
      cap_r    <= cap_nxt;
      rose_r   <= rose_nxt;
      mode_r   <= mode_nxt;
      chg_r    <= chg_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Reset supervisor
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] hold_r, hold_nxt;
  logic             rst_act_nxt;

  // Any cause restarts the full hold; release also waits for the probe
  always_comb begin
    rst_act_nxt = rst_act_r;
    hold_nxt    = hold_r;
    if (cause) begin
      rst_act_nxt = 1'b1;
      hold_nxt    = '0;
    end else if (rst_act_r) begin
      if (hold_r >= CNT_W'(HOLD_CYC - 1) && pr_r == PR_DONE) begin
        rst_act_nxt = 1'b0;
      end else if (hold_r < CNT_W'(HOLD_CYC - 1)) begin
        hold_nxt = hold_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rst_act_r <= 1'b1;
      hold_r    <= '0;
    end else begin
      rst_act_r <= rst_act_nxt;
      hold_r    <= hold_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Window watchdog
  // ------------------------------------------------------------------
  swwd_wd_t         wd_r, wd_nxt;
  logic [CNT_W-1:0] wcnt_r, wcnt_nxt, lo_bound, up_bound;
  logic             fault_r, fault_nxt, settle_r, settle_nxt;
  logic             wd_active, fault_ev;

  // Bound pair chosen by the probed timing-select mode
  always_comb begin
    case (mode_r)
      MODE_PULLUP: begin
        lo_bound = CNT_W'(WDL_P_CYC);
        up_bound = CNT_W'(WDU_P_CYC);
      end
      MODE_CAP: begin
        // Widened first so the product keeps its upper bits
        lo_bound = {12'h000, cap_r[11:0]}
                   * {12'h000, CAP_LO_MUL};
        up_bound = {12'h000, cap_r[11:0]}
                   * {12'h000, CAP_UP_MUL};
      end
      default: begin
        lo_bound = CNT_W'(WDL_F_CYC);
        up_bound = CNT_W'(WDU_F_CYC);
      end
    endcase
  end

  // Reset, manual reset or enable low all park the watchdog
  // Next reset value, so the fault pad lets go with the reset edge
  assign wd_active = ~rst_act_nxt & ~mr_low & sync_r.wd_en;

  // Violations restart the window; a good kick clears the fault
  always_comb begin
    wd_nxt     = wd_r;
    wcnt_nxt   = wcnt_r + 1'b1;
    fault_nxt  = fault_r;
    settle_nxt = settle_r | ~sync_r.wd_en;
    fault_ev   = 1'b0;
    case (wd_r)
      WD_OFF: begin
        wcnt_nxt = '0;
        if (wd_active) begin
          wd_nxt     = settle_r ? WD_SETTLE : WD_FIRST;
          settle_nxt = 1'b0;
        end
      end
      WD_SETTLE: begin
        if (wcnt_r >= SETTLE_CYC - 1'b1) begin
          wd_nxt   = WD_FIRST;
          wcnt_nxt = '0;
        end
      end
      WD_FIRST, WD_WINDOW: begin
        if (kick_fall) begin
          wcnt_nxt = '0;
          wd_nxt   = WD_WINDOW;
          if (wd_r == WD_WINDOW && wcnt_r < lo_bound) begin
            fault_nxt = 1'b1;
            fault_ev  = 1'b1;
          end else begin
            fault_nxt = 1'b0;
          end
        end else if (wcnt_r >= up_bound - 1'b1) begin
          wcnt_nxt  = '0;
          wd_nxt    = WD_WINDOW;
          fault_nxt = 1'b1;
          fault_ev  = 1'b1;
        end
      end
      default: wd_nxt = WD_OFF;
    endcase
    if (!wd_active) begin
      wd_nxt    = WD_OFF;
      fault_nxt = 1'b0;
      fault_ev  = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wd_r     <= WD_OFF;
      wcnt_r   <= '0;
      fault_r  <= 1'b0;
      settle_r <= 1'b0;
    end else begin
      wd_r     <= wd_nxt;
      wcnt_r   <= wcnt_nxt;
      fault_r  <= fault_nxt;
      settle_r <= settle_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Registers, events and interrupt
  // ------------------------------------------------------------------
  logic [2:0]  sts_r, sts_nxt, ien_r, ien_nxt, ev;
  logic [31:0] rdata_r, rdata_nxt;
  logic        irq_r, irq_nxt, rst_prev_r;
  logic        pr_done_prev_r;

  assign ev[EV_RESET] = rst_act_r & ~rst_prev_r;
  assign ev[EV_FAULT] = fault_ev;
  assign ev[EV_PROBE] = (pr_r == PR_DONE) & ~pr_done_prev_r;

  // Sticky status: a new event wins over a same-cycle clear
  always_comb begin
    sts_nxt   = sts_r;
    ien_nxt   = ien_r;
    rdata_nxt = '0;
    if (reg_wr && reg_addr == REG_IRQ_CLR) begin
      sts_nxt = sts_r & ~reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == REG_IRQ_EN) begin
      ien_nxt = reg_wdata[2:0];
    end
    sts_nxt = sts_nxt | ev;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: rdata_nxt = {29'h0, sts_r};
        REG_IRQ_EN: rdata_nxt = {29'h0, ien_r};
        REG_STATE:  rdata_nxt = {23'h0, wd_r, pr_r, mode_r, sync_r.wd_en,
                                 fault_r, rst_act_r};
        REG_CAPCNT: rdata_nxt = {8'h0, cap_r};
        default:    rdata_nxt = '0;
      endcase
    end
    irq_nxt = |(sts_nxt & ien_nxt);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sts_r          <= '0;
      ien_r          <= IRQ_EN_RST;
      rdata_r        <= '0;
      irq_r          <= 1'b0;
      rst_prev_r     <= 1'b1;
      pr_done_prev_r <= 1'b0;
    end else begin
      sts_r          <= sts_nxt;
      ien_r          <= ien_nxt;
      rdata_r        <= rdata_nxt;
      irq_r          <= irq_nxt;
      rst_prev_r     <= rst_act_r;
      pr_done_prev_r <= (pr_r == PR_DONE);
    end
  end

  // ------------------------------------------------------------------
  // Outputs: open-drain pads only ever drive low
  // ------------------------------------------------------------------
  logic pad_low_r;

  always_ff @(posedge clock) begin
    pad_low_r <= 1'b0;
  end

  assign reset_out_n_o           = pad_low_r;
  assign reset_out_n_oe          = rst_act_r;
  assign watchdog_fault_out_n_o  = pad_low_r;
  assign watchdog_fault_out_n_oe = fault_r;
  assign timing_charge_en        = chg_r;
  assign irq                     = irq_r;
  assign reg_rdata               = rdata_r;

endmodule : swwd_core

// ### test/swwd_props.sv
// Checker for the supervisor core, bound beside its ports.
// Assumes pin levels from outside stay put for ten cycles or more.
`timescale 1ns/1ps
module swwd_props
  import swwd_pkg::*;
#(
  parameter int unsigned HOLD_CYC = RST_HOLD_CYC
) (
  input wire logic clock,                   // Core clock
  input wire logic resetn,                  // Sync reset
  input wire logic undervoltage_low,        // Supply low
  input wire logic manual_reset_n,          // Manual reset level
  input wire logic manual_reset_drv,        // Manual reset driven
  input wire logic watchdog_enable_pin,     // Watchdog enable
  input wire logic reset_out_n_o,           // Reset drive value
  input wire logic reset_out_n_oe,          // Reset pulled low
  input wire logic watchdog_fault_out_n_o,  // Fault drive value
  input wire logic watchdog_fault_out_n_oe, // Fault pulled low
  input wire logic irq                      // Interrupt level
);
  // ------------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------------
  // Longer of hold and probe, plus margin for the input stages
  localparam int REL_MAX = (HOLD_CYC > PROBE_CYC) ? HOLD_CYC + 400
                                                  : PROBE_CYC + 400;
  logic [15:0] quiet_r, quiet_nxt, en_r, en_nxt;
  logic        cause;
  // Raw cause leads the synced one, so these counts run slightly ahead
  assign cause = undervoltage_low | (manual_reset_drv & ~manual_reset_n);
  always_comb begin
    quiet_nxt = cause ? 16'h0000 : quiet_r + {15'h0000, &quiet_r == 1'b0};
    en_nxt = watchdog_enable_pin ? en_r + {15'h0000, &en_r == 1'b0} : 16'h0;
  end
  // Saturating, cleared by reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      quiet_r <= 16'h0000;
      en_r    <= 16'h0000;
    end else begin
      quiet_r <= quiet_nxt;
      en_r    <= en_nxt;
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_od_low_only: assert property
    (!reset_out_n_o && !watchdog_fault_out_n_o)
    else $error("open-drain value not low");
  a_uv_asserts_rst: assert property (undervoltage_low [*3]
    |-> ##[0:2] reset_out_n_oe) else $error("undervoltage missed");
  a_mr_asserts_rst: assert property
    ((manual_reset_drv && !manual_reset_n) [*3] |-> ##[0:2] reset_out_n_oe)
    else $error("manual reset missed");
  a_fault_hiz_rst: assert property (reset_out_n_oe [*3]
    |-> !watchdog_fault_out_n_oe) else $error("fault driven in reset");
  a_hold_min: assert property ($fell(reset_out_n_oe)
    |-> quiet_r >= HOLD_CYC) else $error("reset released early");
  a_probe_first: assert property ($fell(reset_out_n_oe)
    |-> quiet_r > PROBE_CYC) else $error("released before probe");
  a_release_bound: assert property (quiet_r == REL_MAX
    |-> !reset_out_n_oe) else $error("reset never released");
  a_en_low_quiet: assert property (!watchdog_enable_pin [*6]
    |-> !watchdog_fault_out_n_oe) else $error("fault while disabled");
  a_mr_no_fault: assert property
    ((manual_reset_drv && !manual_reset_n) [*6] |-> !watchdog_fault_out_n_oe)
    else $error("fault during manual reset");
  a_settle_quiet: assert property (en_r > 16'h4 && en_r < 16'h05DC
    |-> !watchdog_fault_out_n_oe) else $error("fault in settle");
  c_fault: cover property ($rose(watchdog_fault_out_n_oe));
  c_release: cover property ($fell(reset_out_n_oe));
  c_irq: cover property ($rose(irq));
endmodule : swwd_props

bind swwd_core swwd_props #(.HOLD_CYC(HOLD_CYC)) u_swwd_props (.clock,
  .resetn, .undervoltage_low, .manual_reset_n, .manual_reset_drv,
  .watchdog_enable_pin, .reset_out_n_o, .reset_out_n_oe,
  .watchdog_fault_out_n_o, .watchdog_fault_out_n_oe, .irq);

// ### test/swwd_host.sv
// Host processor model: kicks the watchdog, drives manual reset.
// Assumes the bench asks for kicks at least three cycles apart.
`timescale 1ns/1ps
module swwd_host (
  input  wire logic clock,        // Core clock
  input  wire logic kick_req,     // Bench asks for a kick
  input  wire logic mr_low_req,   // Bench asks for manual reset
  input  wire logic mr_float_req, // Bench leaves the pin open
  output logic      kick,         // Kick pin
  output logic      mr_n,         // Manual reset level
  output logic      mr_drv        // Manual reset driven
);
  logic [1:0] low_r = 2'h0;
  // Kick pulse low for two cycles, well over the minimum width
  always @(posedge clock) begin
    if (kick_req) begin
      low_r <= 2'h2;
    end else if (low_r != 2'h0) begin
      low_r <= low_r - 2'h1;
    end
  end
  assign kick = (low_r == 2'h0);
  // Open pin level means nothing; show the active one
  assign mr_drv = !mr_float_req;
  assign mr_n   = !mr_float_req & !mr_low_req;
endmodule : swwd_host

// ### test/tb_swwd_core.sv
// Self-checking bench for the supervisor core with its host model.
// Assumes shortened hold and factory window counts set below.
`timescale 1ns/1ps
module tb_swwd_core;
  import swwd_pkg::*;
  logic        clock = 1'b0, resetn = 1'b0, uv = 1'b0, en = 1'b0;
  logic        mode_pu = 1'b1, kick_req = 1'b0, mr_low = 1'b0;
  logic        mr_float = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic        kick, mr_n, mr_drv, tsel, chg, rst_o, rst_oe, flt_o, flt_oe;
  logic        irq;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [63:0] exp_q[$], ent;
  int          mismatches = 0, n_tests = 0, cycles = 0, t;
  int          cap_len = 0, chg_n = 0;
  always #50 clock = ~clock;
  // Pull-up holds the select pin high; otherwise the pin crosses its
  // threshold after cap_len cycles of charge (0 for an open pin)
  always @(posedge clock) chg_n <= chg ? chg_n + 1 : 0;
  assign tsel = mode_pu | (chg && chg_n >= cap_len);
  swwd_core #(.HOLD_CYC(4000), .WDL_F_CYC(100), .WDU_F_CYC(200),
    .WDL_P_CYC(20), .WDU_P_CYC(60)) u_swwd_core (.clock(clock),
    .resetn(resetn), .undervoltage_low(uv), .manual_reset_n(mr_n),
    .manual_reset_drv(mr_drv), .watchdog_kick_in(kick),
    .watchdog_enable_pin(en), .window_timing_select_pin(tsel),
    .timing_charge_en(chg), .reset_out_n_o(rst_o), .reset_out_n_oe(rst_oe),
    .watchdog_fault_out_n_o(flt_o), .watchdog_fault_out_n_oe(flt_oe),
    .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  swwd_host u_swwd_host (.clock(clock), .kick_req(kick_req),
    .mr_low_req(mr_low), .mr_float_req(mr_float), .kick(kick), .mr_n(mr_n),
    .mr_drv(mr_drv));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // Ends on a falling edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic do_kick();
    @(posedge clock) kick_req <= 1'b1;
    @(posedge clock) kick_req <= 1'b0;
  endtask : do_kick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back({e, m});
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock) reg_rd <= 1'b0;
  endtask : rd
  // Cycles from the cause clearing until the line is let go:
  // two input stages, one register, then the full hold
  task automatic release_chk();
    t = 0;
    while (rst_oe !== 1'b0 && t < 5000) begin
      @(negedge clock);
      t++;
    end
    check("release", 32'(t >= 4003 && t <= 4010), 32'h1);
  endtask : release_chk
  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (rd_d && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      check("reg_rdata", reg_rdata & ent[31:0], ent[63:32]);
    end
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(43));
    cyc(20);
    @(posedge clock) resetn <= 1'b1;
    release_chk();
    rd(REG_IRQ_EN, 32'h0, 32'hFFFFFFFF);
    rd(8'h14, 32'h0, 32'hFFFFFFFF);
    rd(REG_STATE, 32'h8, 32'h18);
    @(posedge clock) en <= 1'b1;
    cyc(1400);
    do_kick(); // settle kick ignored
    cyc(120);
    check("settle", 32'(flt_oe), 32'h0);
    do_kick();
    repeat (3) begin
      cyc(25 + $urandom % 30);
      do_kick();
    end
    cyc(4);
    check("fault good", 32'(flt_oe), 32'h0);
    cyc(8);
    do_kick();
    cyc(4);
    check("fault early", 32'(flt_oe), 32'h1);
    rd(REG_STATUS, 32'h2, 32'h2);
    cyc(1);
    check("irq masked", 32'(irq), 32'h0);
    wr(REG_IRQ_EN, 32'h2);
    cyc(2);
    check("irq set", 32'(irq), 32'h1);
    wr(REG_IRQ_CLR, 32'h2);
    cyc(2);
    check("irq clear", 32'(irq), 32'h0);
    rd(REG_STATUS, 32'h0, 32'h2);
    cyc(28);
    do_kick();
    cyc(4);
    check("fault cleared", 32'(flt_oe), 32'h0);
    cyc(70);
    check("fault late", 32'(flt_oe), 32'h1);
    @(posedge clock) en <= 1'b0;
    cyc(10);
    check("fault off", 32'(flt_oe), 32'h0);
    @(posedge clock) mr_float <= 1'b1;
    cyc(10);
    check("open mr", 32'(rst_oe), 32'h0);
    @(posedge clock) mr_float <= 1'b0;
    en <= 1'b1;
    mr_low <= 1'b1;
    cyc(6);
    check("mr reset", 32'(rst_oe), 32'h1);
    do_kick();
    cyc(10); // level held over a microsecond
    check("mr fault", 32'(flt_oe), 32'h0);
    @(posedge clock) mr_low <= 1'b0;
    release_chk();
    @(posedge clock) mode_pu <= 1'b0;
    uv <= 1'b1;
    cyc(10);
    check("uv reset", 32'(rst_oe), 32'h1);
    @(posedge clock) uv <= 1'b0;
    release_chk();
    rd(REG_STATE, 32'h0, 32'h18);
    rd(REG_STATUS, 32'h1, 32'h1);
    @(posedge clock) en <= 1'b0;
    cyc(10);
    @(posedge clock) en <= 1'b1;
    cyc(1520);
    do_kick();
    cyc(48);
    do_kick();
    cyc(4);
    check("float early", 32'(flt_oe), 32'h1);
    cyc(144);
    do_kick();
    cyc(4);
    check("float good", 32'(flt_oe), 32'h0);
    // Capacitor on the select pin: user bounds, far wider than factory
    @(posedge clock) cap_len <= 20;
    uv <= 1'b1;
    cyc(10);
    @(posedge clock) uv <= 1'b0;
    release_chk();
    rd(REG_STATE, 32'h10, 32'h18);
    rd(REG_CAPCNT, 32'h10, 32'hFFFFFFF0);
    do_kick();
    cyc(300);
    check("cap no late", 32'(flt_oe), 32'h0);
    do_kick();
    cyc(4);
    check("cap early", 32'(flt_oe), 32'h1);
    conclude();
  end
endmodule : tb_swwd_core
